//--- shared/pct_pkg.sv
// package for the compare buffer transfer block of a triangle-wave pwm timer
// assumes a 32-bit ahb-lite slave port with byte addresses in the low 8 bits
package pct_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] PCT_OFS_CYCLE  = 8'h00;
	localparam logic [7:0] PCT_OFS_DUTY_U = 8'h04;
	localparam logic [7:0] PCT_OFS_DUTY_V = 8'h08;
	localparam logic [7:0] PCT_OFS_DUTY_W = 8'h0C;
	localparam logic [7:0] PCT_OFS_CULL   = 8'h10;
	localparam logic [7:0] PCT_OFS_TRIG_A = 8'h14;
	localparam logic [7:0] PCT_OFS_TRIG_B = 8'h18;
	localparam logic [7:0] PCT_OFS_OPT_A  = 8'h1C;
	localparam logic [7:0] PCT_OFS_OPT_C  = 8'h20;
	localparam logic [7:0] PCT_OFS_STATUS = 8'h24;
	localparam logic [7:0] PCT_OFS_COUNT  = 8'h28;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PCT_OPTA_ANYTIME = 0;
	localparam int PCT_OPTA_RUN     = 1;
	localparam int PCT_OPTC_CULL_EN = 0;

	// ----------------------------------------------------------------
	// reset values and fixed counts
	// ----------------------------------------------------------------
	localparam logic [15:0] PCT_RST_CYCLE  = 16'h0100;
	localparam logic [15:0] PCT_RST_DUTY   = 16'h0000;
	localparam logic [15:0] PCT_RST_TRIG   = 16'h0000;
	localparam logic [15:0] PCT_VALLEY_CNT = 16'h0001;
	localparam logic [1:0]  PCT_RST_OPT_A  = 2'h0;
	localparam logic        PCT_RST_OPT_C  = 1'h0;

	// culling option: bit 6 crest enable, bit 5 valley enable, bits 4:0 count
	typedef struct packed {
		logic       crest_irq_enable;
		logic       valley_irq_enable;
		logic [4:0] culling_count;
	} pct_cull_opt_t;

	localparam pct_cull_opt_t PCT_RST_CULL = '{1'b0, 1'b0, 5'h00};

	// the seven registers that move together into their working buffers
	typedef struct packed {
		logic [15:0]   cycle_compare;
		logic [15:0]   duty_compare_u;
		logic [15:0]   duty_compare_v;
		logic [15:0]   duty_compare_w;
		pct_cull_opt_t culling_option;
		logic [15:0]   adc_trigger_compare_a;
		logic [15:0]   adc_trigger_compare_b;
	} pct_set_t;

	localparam pct_set_t PCT_RST_SET = '{PCT_RST_CYCLE, PCT_RST_DUTY, PCT_RST_DUTY,
		PCT_RST_DUTY, PCT_RST_CULL, PCT_RST_TRIG, PCT_RST_TRIG};

endpackage

//--- core/pct_cull.sv
// interrupt culling counter for crest and valley events
// assumes event inputs are one-cycle pulses on hclk
`timescale 1ns/1ps
module pct_cull (
	input  wire logic                   hclk,       // clock
	input  wire logic                   hresetn,    // async reset, low
	input  wire logic                   clear,      // culling option written
	input  wire logic                   crest_evt,  // raw crest pulse
	input  wire logic                   valley_evt, // raw valley pulse
	input  wire pct_pkg::pct_cull_opt_t opt,        // working culling option
	output logic                        crest_irq,  // crest left after culling
	output logic                        valley_irq  // valley left after culling
);
	import pct_pkg::*;

	logic [4:0] cnt_reg;
	logic       evt;
	logic       fire;

	// ----------------------------------------------------------------
	// culling
	// ----------------------------------------------------------------
	assign evt = (crest_evt & opt.crest_irq_enable)
		| (valley_evt & opt.valley_irq_enable);
	assign fire = evt & (cnt_reg == opt.culling_count);
	assign crest_irq = fire & crest_evt;
	assign valley_irq = fire & valley_evt;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 5'h00;
		end else if (clear) begin
			cnt_reg <= 5'h00;
		end else if (evt) begin
			cnt_reg <= fire ? 5'h00 : 5'(cnt_reg + 5'h01);
		end
	end

	cull_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		clear |=> cnt_reg == 5'h00) else $error("culling count not cleared");
	cull_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(crest_irq | valley_irq) |-> cnt_reg == opt.culling_count)
		else $error("interrupt passed before culling count");

endmodule

//--- core/pct_top.sv
// compare buffer transfer block of a three-phase triangle-wave pwm timer
// assumes a single ahb-lite master, whole-word transfers, one clock domain
`timescale 1ns/1ps
module pct_top (
	input  wire logic        hclk,                     // bus and timer clock
	input  wire logic        hresetn,                  // async reset, low
	input  wire logic        hsel,                     // slave select
	input  wire logic [31:0] haddr,                    // byte address
	input  wire logic [1:0]  htrans,                   // transfer type
	input  wire logic        hwrite,                   // write when high
	input  wire logic [2:0]  hsize,                    // word only
	input  wire logic [31:0] hwdata,                   // write data
	input  wire logic        hready,                   // bus ready
	output logic             hreadyout,                // always ready
	output logic [31:0]      hrdata,                   // read data
	output logic             hresp,                    // always okay
	output logic [2:0]       positive_phase_output,    // u v w top gates
	output logic [2:0]       negative_phase_output,    // u v w bottom gates
	output logic             crest_interrupt,          // culled crest pulse
	output logic             valley_interrupt,         // culled valley pulse
	output logic [2:0]       duty_match_interrupt,     // per-phase match pulse
	output logic [15:0]      adc_trigger_compare_a,    // working trigger a
	output logic [15:0]      adc_trigger_compare_b     // working trigger b
);
	import pct_pkg::*;

	// ----------------------------------------------------------------
	// register field update, shared by the software and working sets
	// ----------------------------------------------------------------
	function automatic pct_set_t put_field(pct_set_t s, logic [7:0] a, logic [31:0] d);
		pct_set_t r;
		r = s;
		case (a)
			PCT_OFS_CYCLE:  r.cycle_compare = d[15:0];
			PCT_OFS_DUTY_U: r.duty_compare_u = d[15:0];
			PCT_OFS_DUTY_V: r.duty_compare_v = d[15:0];
			PCT_OFS_DUTY_W: r.duty_compare_w = d[15:0];
			PCT_OFS_CULL:   r.culling_option = d[6:0];
			PCT_OFS_TRIG_A: r.adc_trigger_compare_a = d[15:0];
			PCT_OFS_TRIG_B: r.adc_trigger_compare_b = d[15:0];
			default:        r = s;
		endcase
		return r;
	endfunction

	logic        wr_ph_reg;
	logic [7:0]  addr_reg;
	logic [31:0] hrdata_reg;
	logic        wr_en;
	logic        wr_u;
	logic        wr_cull;
	pct_set_t    sr_reg;
	pct_set_t    wb_reg;
	logic [1:0]  opt_a_reg;
	logic        opt_c_reg;
	logic        pend_reg;
	logic [15:0] cnt_reg;
	logic        up_reg;
	logic        anytime;
	logic        cull_en;
	logic        batch_mode;
	logic        inter_mode;
	logic        run;
	logic        crest_hit;
	logic        valley_hit;
	logic        turn;
	logic        crest_irq;
	logic        valley_irq;
	logic        xfer_tick;
	logic        do_xfer;
	logic [2:0]  match;
	logic [2:0]  lock_reg;
	logic [15:0] duty [3];
	logic [31:0] rd_mux;

	// ----------------------------------------------------------------
	// ahb-lite slave: zero wait, always okay
	// ----------------------------------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;
	assign wr_en = wr_ph_reg;
	assign wr_u = wr_en & (addr_reg == PCT_OFS_DUTY_U);
	assign wr_cull = wr_en & (addr_reg == PCT_OFS_CULL);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ph_reg <= 1'b0;
			addr_reg <= 8'h00;
		end else if (hready) begin
			wr_ph_reg <= hsel & htrans[1] & hwrite;
			addr_reg <= haddr[7:0];
		end
	end

	// read data is captured in the address phase so it stands from the
	// start of the data phase; unmapped reads return zero
	always_comb begin
		case (haddr[7:0])
			PCT_OFS_CYCLE:  rd_mux = {16'h0000, sr_reg.cycle_compare};
			PCT_OFS_DUTY_U: rd_mux = {16'h0000, sr_reg.duty_compare_u};
			PCT_OFS_DUTY_V: rd_mux = {16'h0000, sr_reg.duty_compare_v};
			PCT_OFS_DUTY_W: rd_mux = {16'h0000, sr_reg.duty_compare_w};
			PCT_OFS_CULL:   rd_mux = {25'h0000000, sr_reg.culling_option};
			PCT_OFS_TRIG_A: rd_mux = {16'h0000, sr_reg.adc_trigger_compare_a};
			PCT_OFS_TRIG_B: rd_mux = {16'h0000, sr_reg.adc_trigger_compare_b};
			PCT_OFS_OPT_A:  rd_mux = {30'h00000000, opt_a_reg};
			PCT_OFS_OPT_C:  rd_mux = {31'h00000000, opt_c_reg};
			PCT_OFS_STATUS: rd_mux = {24'h000000, pend_reg, up_reg, lock_reg,
				positive_phase_output};
			PCT_OFS_COUNT:  rd_mux = {16'h0000, cnt_reg};
			default:        rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata_reg <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// software registers and mode decode
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sr_reg <= PCT_RST_SET;
			opt_a_reg <= PCT_RST_OPT_A;
			opt_c_reg <= PCT_RST_OPT_C;
		end else if (wr_en) begin
			sr_reg <= put_field(sr_reg, addr_reg, hwdata);
			if (addr_reg == PCT_OFS_OPT_A) begin
				opt_a_reg <= hwdata[1:0];
			end
			if (addr_reg == PCT_OFS_OPT_C) begin
				opt_c_reg <= hwdata[PCT_OPTC_CULL_EN];
			end
		end
	end

	assign anytime = opt_a_reg[PCT_OPTA_ANYTIME];
	assign run = opt_a_reg[PCT_OPTA_RUN];
	assign cull_en = opt_c_reg;
	// batch_mode only feeds the checks: with culling off every turn is a transfer tick
	assign batch_mode = ~anytime & ~cull_en
		& (sr_reg.culling_option.culling_count == 5'h00);
	assign inter_mode = ~anytime & cull_en;

	// ----------------------------------------------------------------
	// triangle counter: up to the cycle value, down to 0001
	// ----------------------------------------------------------------
	assign crest_hit = run & up_reg & (cnt_reg == wb_reg.cycle_compare);
	assign valley_hit = run & ~up_reg & (cnt_reg == PCT_VALLEY_CNT);
	assign turn = crest_hit | valley_hit;

	// a cycle value below the count is missed; the 16-bit wrap finds it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 16'h0000;
			up_reg <= 1'b1;
		end else if (!run) begin
			cnt_reg <= 16'h0000;
			up_reg <= 1'b1;
		end else if (crest_hit) begin
			cnt_reg <= 16'(cnt_reg - 16'h0001);
			up_reg <= 1'b0;
		end else if (valley_hit) begin
			cnt_reg <= 16'(cnt_reg + 16'h0001);
			up_reg <= 1'b1;
		end else begin
			cnt_reg <= up_reg ? 16'(cnt_reg + 16'h0001)
				: 16'(cnt_reg - 16'h0001);
		end
	end

	// ----------------------------------------------------------------
	// interrupt culling and transfer timing
	// ----------------------------------------------------------------
	pct_cull u_cull (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.clear      (wr_cull),
		.crest_evt  (crest_hit),
		.valley_evt (valley_hit),
		.opt        (wb_reg.culling_option),
		.crest_irq  (crest_irq),
		.valley_irq (valley_irq)
	);

	assign xfer_tick = inter_mode ? (crest_irq | valley_irq)
		: turn;
	assign do_xfer = ~anytime & pend_reg & xfer_tick;

	// a duty u write landing with a transfer re-arms, since the transfer
	// copies the value held before that write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_reg <= 1'b0;
		end else if (wr_u && !anytime) begin
			pend_reg <= 1'b1;
		end else if (do_xfer || anytime) begin
			pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wb_reg <= PCT_RST_SET;
		end else if (wr_en && anytime) begin
			wb_reg <= put_field(wb_reg, addr_reg, hwdata);
		end else if (do_xfer) begin
			wb_reg <= sr_reg;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crest_interrupt <= 1'b0;
			valley_interrupt <= 1'b0;
		end else begin
			crest_interrupt <= crest_irq;
			valley_interrupt <= valley_irq;
		end
	end

	assign adc_trigger_compare_a = wb_reg.adc_trigger_compare_a;
	assign adc_trigger_compare_b = wb_reg.adc_trigger_compare_b;

	// ----------------------------------------------------------------
	// per-phase compare, lockout and output
	// ----------------------------------------------------------------
	assign duty[0] = wb_reg.duty_compare_u;
	assign duty[1] = wb_reg.duty_compare_v;
	assign duty[2] = wb_reg.duty_compare_w;

	for (genvar i = 0; i < 3; i++) begin : g_phase
		assign match[i] = run & (cnt_reg == duty[i]);

		// only the first match per direction moves the output
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				lock_reg[i] <= 1'b0;
			end else if (turn) begin
				lock_reg[i] <= 1'b0;
			end else if (match[i]) begin
				lock_reg[i] <= 1'b1;
			end
		end

		// an unlocked match wins over the crest and valley force
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				positive_phase_output[i] <= 1'b0;
				negative_phase_output[i] <= 1'b1;
			end else if (match[i] && !lock_reg[i]) begin
				positive_phase_output[i] <= ~up_reg;
				negative_phase_output[i] <= up_reg;
			end else if (crest_hit) begin
				positive_phase_output[i] <= 1'b1;
				negative_phase_output[i] <= 1'b0;
			end else if (valley_hit) begin
				positive_phase_output[i] <= 1'b0;
				negative_phase_output[i] <= 1'b1;
			end
		end

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				duty_match_interrupt[i] <= 1'b0;
			end else begin
				duty_match_interrupt[i] <= match[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	anytime_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		anytime && wr_u |=> wb_reg.duty_compare_u == $past(hwdata[15:0]))
		else $error("anytime write not applied at once");
	batch_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
		batch_mode && pend_reg && turn |-> do_xfer)
		else $error("batch transfer missed at crest or valley");
	xfer_copy_a: assert property (@(posedge hclk) disable iff (!hresetn)
		do_xfer && !wr_en |=> wb_reg == $past(sr_reg))
		else $error("transfer did not copy the seven registers");
	no_arm_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!anytime && !pend_reg |=> $stable(wb_reg))
		else $error("working set changed without a duty u write");
	inter_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
		inter_mode && do_xfer |-> crest_irq || valley_irq)
		else $error("intermittent transfer off a culled interrupt");
	pend_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		do_xfer && !wr_u |=> !pend_reg)
		else $error("pending flag survived its transfer");
	down_no_crest_a: assert property (@(posedge hclk) disable iff (!hresetn)
		run && !up_reg && !valley_hit |=> !up_reg)
		else $error("counter turned while counting down");
	wrap_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
		run && up_reg && cnt_reg == 16'hFFFF && !crest_hit |=> cnt_reg == 16'h0000)
		else $error("counter did not wrap upward");
	lock_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lock_reg[0] && !turn |=> $stable(positive_phase_output[0]))
		else $error("locked phase output moved");
	crest_force_a: assert property (@(posedge hclk) disable iff (!hresetn)
		crest_hit && !match[0] |=> positive_phase_output[0])
		else $error("crest did not force output high");
	match_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
		match[0] && lock_reg[0] |=> duty_match_interrupt[0])
		else $error("locked match raised no interrupt");
	valley_force_a: assert property (@(posedge hclk) disable iff (!hresetn)
		valley_hit && !match[0] |=> !positive_phase_output[0])
		else $error("valley did not force output low");
	crest_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!wb_reg.culling_option.crest_irq_enable |=> !crest_interrupt)
		else $error("disabled crest interrupt was output");

endmodule

//--- testbench/pct_gate_model.sv
// gate driver stand-in that watches the six pwm lines of the inverter
// assumes gate levels are registered on hclk with no dead time inserted
`timescale 1ns/1ps
module pct_gate_model (
	input  wire logic       hclk,    // clock
	input  wire logic       hresetn, // async reset, low
	input  wire logic [2:0] gate_hi, // top gates u v w
	input  wire logic [2:0] gate_lo, // bottom gates u v w
	output logic            fault    // both gates of one leg seen on
);
	// a leg with both switches on shorts the dc link, so the fault latches
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fault <= 1'b0;
		end else if ((gate_hi & gate_lo) != 3'h0) begin
			fault <= 1'b1;
		end
	end
endmodule

//--- testbench/pct_top_test.sv
// self-checking bench for the compare buffer transfer block
// assumes one ahb-lite master on the bus and a gate model on the pwm lines
`timescale 1ns/1ps
module pct_top_test;
	import pct_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	localparam logic [15:0] CYC  = 16'h0020;
	localparam int          HALF = int'(CYC) - 1;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire logic   hready;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [2:0]  pos;
	logic [2:0]  neg;
	logic        crest;
	logic        valley;
	logic [2:0]  dmi;
	logic [15:0] trig_a;
	logic [15:0] trig_b;
	logic        gate_fault;
	logic [31:0] rd;
	int          n_fail;
	int          checks_done;
	int          cycles;
	int          n_crest;
	int          gap;
	int          t0;

	assign hready = hreadyout;

	pct_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.positive_phase_output(pos), .negative_phase_output(neg),
		.crest_interrupt(crest), .valley_interrupt(valley),
		.duty_match_interrupt(dmi), .adc_trigger_compare_a(trig_a),
		.adc_trigger_compare_b(trig_b));

	pct_gate_model u_gate (.hclk(hclk), .hresetn(hresetn), .gate_hi(pos), .gate_lo(neg),
		.fault(gate_fault));

	initial hclk = 1'b0;
	always #5 hclk = ~hclk;

	always @(posedge hclk) begin
		cycles <= cycles + 1;
		if (crest === 1'b1)
			n_crest <= n_crest + 1;
		if (cycles == 10000) begin
			n_fail++;
			$display("timeout after %0d cycles", cycles);
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// single word transfer; a hang here is cut by the cycle ceiling
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	function automatic logic sig(input int sel);
		case (sel)
			0: return crest;
			1: return valley;
			2: return crest | valley;
			default: return dmi[0];
		endcase
	endfunction

	task automatic wait_ev(input int sel);
		do @(posedge hclk); while (sig(sel) !== 1'b1);
	endtask

	task automatic measure(input int sel, output int n);
		wait_ev(sel);
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (sig(sel) !== 1'b1);
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		n_fail = 0;
		checks_done = 0;
		cycles = 0;
		n_crest = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check("pos", 32'(pos), 32'h0);
		check("neg", 32'(neg), 32'h7);
		check("trig_a", 32'(trig_a), 32'h0);
		check("hresp", 32'(hresp), 32'h0);
		bus(1'b0, PCT_OFS_CYCLE, 32'h0);
		check("cycle", rd, 32'(PCT_RST_CYCLE));
		$display("test reset done");

		// buffered writes stay put until duty u is written
		bus(1'b1, PCT_OFS_CYCLE, 32'(CYC));
		bus(1'b1, PCT_OFS_CULL, 32'h60);
		bus(1'b1, PCT_OFS_TRIG_A, 32'h1234);
		bus(1'b1, PCT_OFS_OPT_A, 32'h2);
		repeat (600) @(posedge hclk);
		check("trig_a", 32'(trig_a), 32'h0);
		bus(1'b1, PCT_OFS_DUTY_U, 32'h10);
		bus(1'b0, PCT_OFS_STATUS, 32'h0);
		check("pending", 32'(rd[7]), 32'h1);
		do @(posedge hclk); while (trig_a !== 16'h1234);
		bus(1'b0, PCT_OFS_STATUS, 32'h0);
		check("pending", 32'(rd[7]), 32'h0);
		measure(2, gap);
		check("event gap", 32'(gap), 32'(HALF));
		bus(1'b1, PCT_OFS_TRIG_A, 32'h4321);
		measure(2, gap);
		check("trig_a", 32'(trig_a), 32'h1234);
		$display("test batch done");

		// valley only
		bus(1'b1, PCT_OFS_CULL, 32'h20);
		bus(1'b1, PCT_OFS_DUTY_U, 32'h10);
		// an event in the write's own data phase comes before the arm
		wait_ev(2);
		if (trig_a !== 16'h4321)
			wait_ev(2);
		check("trig_a", 32'(trig_a), 32'h4321);
		@(posedge hclk);
		t0 = n_crest;
		measure(1, gap);
		check("valley gap", 32'(gap), 32'(2 * HALF));
		check("crest count", 32'(n_crest - t0), 32'h0);
		$display("test valley only done");

		// intermittent: transfer rides on the surviving interrupt
		bus(1'b1, PCT_OFS_OPT_C, 32'h1);
		bus(1'b1, PCT_OFS_CULL, 32'h61);
		bus(1'b1, PCT_OFS_TRIG_A, 32'h5678);
		bus(1'b1, PCT_OFS_DUTY_U, 32'h10);
		wait_ev(1);
		if (trig_a !== 16'h5678)
			wait_ev(1);
		check("trig_a", 32'(trig_a), 32'h5678);
		measure(2, gap);
		check("culled gap", 32'(gap), 32'(2 * HALF));
		$display("test intermittent done");

		// anytime
		bus(1'b1, PCT_OFS_OPT_A, 32'h3);
		bus(1'b1, PCT_OFS_TRIG_B, 32'h0ABC);
		@(posedge hclk);
		check("trig_b", 32'(trig_b), 32'h0ABC);
		bus(1'b1, PCT_OFS_CULL, 32'h60);
		bus(1'b1, PCT_OFS_DUTY_W, 32'hFFFF);
		wait_ev(0);
		@(posedge hclk);
		check("pos_w", 32'(pos[2]), 32'h1);
		wait_ev(1);
		@(posedge hclk);
		check("pos_w", 32'(pos[2]), 32'h0);
		wait_ev(3);
		t0 = cycles;
		bus(1'b1, PCT_OFS_DUTY_U, 32'h18);
		wait_ev(3);
		check("match gap", 32'(cycles - t0), 32'h8);
		@(posedge hclk);
		check("pos_u", 32'(pos[0]), 32'h0);
		wait_ev(3);
		@(posedge hclk);
		check("pos_u", 32'(pos[0]), 32'h1);
		check("pos", 32'(pos), 32'h7);
		check("neg", 32'(neg), 32'h0);
		check("gate fault", 32'(gate_fault), 32'h0);
		$display("test anytime done");
		end_of_test();
	end
endmodule
